/* File: hdl/mdm_exec_unit.sv */
`timescale 1ns/100ps

module mdm_exec_unit
  import mdm_pkg::*;
(
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        reset,
  // Issue from the decoder
  input  wire logic        start,
  input  wire logic [2:0]  op,
  input  wire logic        sgn,
  input  wire logic [31:0] opa,
  input  wire logic [31:0] opb,
  input  wire logic [31:0] acc_in,
  // Write-back and pipeline control
  output logic             busy_r,
  output logic             done_r,
  output logic [31:0]      result_lo_r,
  output logic [31:0]      result_hi_r,
  output logic             carry_r
);

  // ----------------------------------------------------------------
  // Local types and signals
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    MDM_IDLE,
    MDM_MUL16,
    MDM_MAC_PROD,
    MDM_MAC_ADD,
    MDM_DIV_RUN
  } mdm_state_t;

  mdm_state_t  state_r;
  mdm_state_t  state_nxt;
  logic [15:0] a_r;
  logic [15:0] a_nxt;
  logic [15:0] b_r;
  logic [15:0] b_nxt;
  logic [31:0] acc_r;
  logic [31:0] acc_nxt;
  logic [31:0] prod_r;
  logic [31:0] prod_nxt;
  logic        sgn_r;
  logic        sgn_nxt;
  logic        busy_nxt;
  logic        done_nxt;
  logic [31:0] result_lo_nxt;
  logic [31:0] result_hi_nxt;
  logic        carry_nxt;
  logic        div_load;
  logic        div_half;
  logic [31:0] div_quot;
  logic [31:0] div_rem;
  logic        div_done;
  logic [17:0] mul8_full;
  logic [33:0] mul16_full;
  logic [32:0] mac_sum;
  logic        mac_flow;
  logic        issue;

  // ----------------------------------------------------------------
  // Arithmetic
  // ----------------------------------------------------------------
  // Operands are widened by one bit so one signed multiplier covers both signs
  assign mul8_full  = 18'($signed({sgn & opa[7], opa[7:0]}) * $signed({sgn & opb[7], opb[7:0]}));
  assign mul16_full = 34'($signed({sgn_r & a_r[15], a_r}) * $signed({sgn_r & b_r[15], b_r}));

  // Carry out for unsigned, sign clash for signed: both overflow and underflow
  assign mac_sum  = {1'b0, acc_r} + {1'b0, prod_r};
  assign mac_flow = sgn_r ? ((acc_r[31] == prod_r[31]) && (mac_sum[31] != acc_r[31]))
                          : mac_sum[32];

  // ----------------------------------------------------------------
  // Divider
  // ----------------------------------------------------------------
  // A new issue is only accepted while idle, so busy_r holds the pipeline
  assign issue    = start && (state_r == MDM_IDLE);
  assign div_load = issue && ((op == MDM_OP_DIV16) || (op == MDM_OP_DIV32));
  assign div_half = (op == MDM_OP_DIV16);

  mdm_divider u_divider
  (
    .clk      (clk),
    .reset    (reset),
    .load     (div_load),
    .half     (div_half),
    .dividend (opa),
    .divisor  (opb),
    .quot_r   (div_quot),
    .rem_r    (div_rem),
    .done_r   (div_done)
  );

  // ----------------------------------------------------------------
  // Sequencer next state
  // ----------------------------------------------------------------
  // No interrupt request exists here; status only reaches carry_r
  always_comb
  begin
    state_nxt     = state_r;
    a_nxt         = a_r;
    b_nxt         = b_r;
    acc_nxt       = acc_r;
    prod_nxt      = prod_r;
    sgn_nxt       = sgn_r;
    busy_nxt      = busy_r;
    done_nxt      = 1'b0;
    result_lo_nxt = result_lo_r;
    result_hi_nxt = result_hi_r;
    carry_nxt     = carry_r;
    case (state_r)
      MDM_IDLE:
      begin
        if (issue)
        begin
          a_nxt   = opa[15:0];
          b_nxt   = opb[15:0];
          acc_nxt = acc_in;
          sgn_nxt = sgn;
          case (op)
            MDM_OP_MUL8:
            begin
              result_lo_nxt = {16'h0000, mul8_full[15:0]};
              result_hi_nxt = MDM_RESULT_RST;
              done_nxt      = 1'b1;
            end
            MDM_OP_MUL16:
            begin
              state_nxt = MDM_MUL16;
              busy_nxt  = 1'b1;
            end
            MDM_OP_DIV16, MDM_OP_DIV32:
            begin
              state_nxt = MDM_DIV_RUN;
              busy_nxt  = 1'b1;
            end
            MDM_OP_MAC:
            begin
              state_nxt = MDM_MAC_PROD;
              busy_nxt  = 1'b1;
            end
            default:
            begin
              // Unknown codes complete at once with the result unchanged
              done_nxt = 1'b1;
            end
          endcase
        end
      end
      MDM_MUL16:
      begin
        result_lo_nxt = mul16_full[31:0];
        result_hi_nxt = MDM_RESULT_RST;
        done_nxt      = 1'b1;
        busy_nxt      = 1'b0;
        state_nxt     = MDM_IDLE;
      end
      MDM_MAC_PROD:
      begin
        // Product is registered first so the adder sees a short path
        prod_nxt  = mul16_full[31:0];
        state_nxt = MDM_MAC_ADD;
      end
      MDM_MAC_ADD:
      begin
        result_lo_nxt = mac_sum[31:0];
        result_hi_nxt = MDM_RESULT_RST;
        carry_nxt     = mac_flow;
        done_nxt      = 1'b1;
        busy_nxt      = 1'b0;
        state_nxt     = MDM_IDLE;
      end
      MDM_DIV_RUN:
      begin
        // The divider's done edge is the copy cycle; a separate state would cost one clock too many
        if (div_done)
        begin
          result_lo_nxt = div_quot;
          result_hi_nxt = div_rem;
          done_nxt      = 1'b1;
          busy_nxt      = 1'b0;
          state_nxt     = MDM_IDLE;
        end
      end
      default:
      begin
        state_nxt = MDM_IDLE;
        busy_nxt  = 1'b0;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // Sequencer registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      state_r     <= MDM_IDLE;
      a_r         <= 16'h0000;
      b_r         <= 16'h0000;
      acc_r       <= MDM_RESULT_RST;
      prod_r      <= MDM_RESULT_RST;
      sgn_r       <= 1'b0;
      busy_r      <= 1'b0;
      done_r      <= 1'b0;
      result_lo_r <= MDM_RESULT_RST;
      result_hi_r <= MDM_RESULT_RST;
      carry_r     <= 1'b0;
    end
    else
    begin
      state_r     <= state_nxt;
      a_r         <= a_nxt;
      b_r         <= b_nxt;
      acc_r       <= acc_nxt;
      prod_r      <= prod_nxt;
      sgn_r       <= sgn_nxt;
      busy_r      <= busy_nxt;
      done_r      <= done_nxt;
      result_lo_r <= result_lo_nxt;
      result_hi_r <= result_hi_nxt;
      carry_r     <= carry_nxt;
    end
  end

endmodule // mdm_exec_unit

/* File: hdl/mdm_pkg.sv */
package mdm_pkg;

  // ----------------------------------------------------------------
  // Operation codes on the op port
  // ----------------------------------------------------------------
  localparam logic [2:0] MDM_OP_MUL8  = 3'h0;
  localparam logic [2:0] MDM_OP_MUL16 = 3'h1;
  localparam logic [2:0] MDM_OP_DIV16 = 3'h2;
  localparam logic [2:0] MDM_OP_DIV32 = 3'h3;
  localparam logic [2:0] MDM_OP_MAC   = 3'h4;

  // ----------------------------------------------------------------
  // Execution lengths in clock cycles, start edge included
  // ----------------------------------------------------------------
  localparam int MDM_CYC_MUL8  = 1;
  localparam int MDM_CYC_MUL16 = 2;
  localparam int MDM_CYC_DIV16 = 9;
  localparam int MDM_CYC_DIV32 = 17;
  localparam int MDM_CYC_MAC   = 3;

  // ----------------------------------------------------------------
  // Divider shape: quotient bits retired per clock
  // ----------------------------------------------------------------
  localparam int MDM_DIV_BITS_PER_CYC = 2;
  // One cycle of the divide budget is spent copying the result out
  localparam int MDM_DIV16_STEPS = MDM_CYC_DIV16 - 1;
  localparam int MDM_DIV32_STEPS = MDM_CYC_DIV32 - 1;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [31:0] MDM_RESULT_RST = 32'h0000_0000;
  localparam logic [4:0]  MDM_CNT_RST    = 5'h00;

endpackage

/* File: hdl/mdm_divider.sv */
`timescale 1ns/100ps

module mdm_divider
  import mdm_pkg::*;
(
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        reset,
  // Request
  input  wire logic        load,
  input  wire logic        half,
  input  wire logic [31:0] dividend,
  input  wire logic [31:0] divisor,
  // Answer
  output logic [31:0]      quot_r,
  output logic [31:0]      rem_r,
  output logic             done_r
);

  // ----------------------------------------------------------------
  // Restoring divide step, several bits per clock
  // ----------------------------------------------------------------
  function automatic logic [63:0] mdm_step(input logic [31:0] r, input logic [31:0] q,
                                           input logic [31:0] d);
    logic [32:0] part;
    logic [31:0] rr;
    logic [31:0] qq;
    logic        ge;
    rr = r;
    qq = q;
    for (int i = 0; i < MDM_DIV_BITS_PER_CYC; i++)
    begin
      part = {rr, qq[31]};
      ge   = (part >= {1'b0, d});
      if (ge)
      begin
        part = part - {1'b0, d};
      end
      rr = part[31:0];
      qq = {qq[30:0], ge};
    end
    return {rr, qq};
  endfunction

  logic [31:0] quot_nxt;
  logic [31:0] rem_nxt;
  logic [31:0] dvs_r;
  logic [31:0] dvs_nxt;
  logic [4:0]  cnt_r;
  logic [4:0]  cnt_nxt;
  logic        run_r;
  logic        run_nxt;
  logic        done_nxt;
  logic [31:0] load_q;
  logic [31:0] load_d;
  logic [63:0] step_load;
  logic [63:0] step_run;

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  // Half width parks the dividend high so its MSB leaves first
  assign load_q    = half ? {dividend[15:0], 16'h0000} : dividend;
  assign load_d    = half ? {16'h0000, divisor[15:0]} : divisor;
  assign step_load = mdm_step(32'h0000_0000, load_q, load_d);
  assign step_run  = mdm_step(rem_r, quot_r, dvs_r);

  // First step is taken on the load edge to fit the cycle budget
  always_comb
  begin
    quot_nxt = quot_r;
    rem_nxt  = rem_r;
    dvs_nxt  = dvs_r;
    cnt_nxt  = cnt_r;
    run_nxt  = run_r;
    done_nxt = 1'b0;
    if (load)
    begin
      dvs_nxt  = load_d;
      rem_nxt  = step_load[63:32];
      quot_nxt = step_load[31:0];
      // One step per clock: the load edge and the last step at zero both count
      cnt_nxt  = half ? 5'(MDM_DIV16_STEPS - 2)
                      : 5'(MDM_DIV32_STEPS - 2);
      run_nxt  = 1'b1;
    end
    else if (run_r)
    begin
      rem_nxt  = step_run[63:32];
      quot_nxt = step_run[31:0];
      cnt_nxt  = cnt_r - 5'h01;
      if (cnt_r == MDM_CNT_RST)
      begin
        run_nxt  = 1'b0;
        done_nxt = 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      quot_r <= MDM_RESULT_RST;
      rem_r  <= MDM_RESULT_RST;
      dvs_r  <= MDM_RESULT_RST;
      cnt_r  <= MDM_CNT_RST;
      run_r  <= 1'b0;
      done_r <= 1'b0;
    end
    else
    begin
      quot_r <= quot_nxt;
      rem_r  <= rem_nxt;
      dvs_r  <= dvs_nxt;
      cnt_r  <= cnt_nxt;
      run_r  <= run_nxt;
      done_r <= done_nxt;
    end
  end

endmodule // mdm_divider

/* File: sim/mdm_exec_unit_properties.sv */
`timescale 1ns/100ps

module mdm_exec_unit_props
  import mdm_pkg::*;
(
  // Clock and reset
  input wire logic        clk,
  input wire logic        reset,
  // Issue
  input wire logic        start,
  input wire logic [2:0]  op,
  input wire logic        sgn,
  input wire logic [31:0] opa,
  input wire logic [31:0] opb,
  input wire logic [31:0] acc_in,
  // Write-back
  input wire logic        busy_r,
  input wire logic        done_r,
  input wire logic [31:0] result_lo_r,
  input wire logic [31:0] result_hi_r,
  input wire logic        carry_r
);
  logic [31:0] a_q;
  logic [31:0] b_q;
  logic [31:0] acc_q;
  logic [32:0] usum;

  default clocking @(posedge clk); endclocking
  default disable iff (reset);

  // Operands kept from the issuing edge; no new issue lands while busy
  always_ff @(posedge clk or posedge reset)
    if (reset)
      {a_q, b_q, acc_q} <= '0;
    else if (start && !busy_r)
      {a_q, b_q, acc_q} <= {opa, opb, acc_in};

  // Unsigned accumulate with its carry out
  assign usum = {1'b0, acc_q} + a_q[15:0] * b_q[15:0];

  sequence s_take(logic [2:0] k);
    start && !busy_r && op == k;
  endsequence

  // ----------------------------------------------------------------
  // Timing and values at write-back
  // ----------------------------------------------------------------
  property p_mul8_time;
    s_take(MDM_OP_MUL8) |=> done_r && !busy_r;
  endproperty
  a_mul8_time: assert property (p_mul8_time) else $error("byte multiply late");

  property p_mul8_val;
    s_take(MDM_OP_MUL8) ##0 !sgn |=>
      result_lo_r == {16'h0, {8'h0, a_q[7:0]} * {8'h0, b_q[7:0]}} && result_hi_r == 32'h0;
  endproperty
  a_mul8_val: assert property (p_mul8_val) else $error("byte product wrong");

  property p_mul16;
    s_take(MDM_OP_MUL16) |=> busy_r && !done_r ##1 done_r && !busy_r;
  endproperty
  a_mul16: assert property (p_mul16) else $error("word multiply timing");

  property p_div16;
    s_take(MDM_OP_DIV16) |=> (busy_r && !done_r)[*8] ##1 done_r;
  endproperty
  a_div16: assert property (p_div16) else $error("short divide timing");

  property p_div16_val;
    s_take(MDM_OP_DIV16) ##0 opb[15:0] != 16'h0 |-> ##9
      result_lo_r == a_q[15:0] / b_q[15:0] && result_hi_r == a_q[15:0] % b_q[15:0];
  endproperty
  a_div16_val: assert property (p_div16_val) else $error("short divide value");

  property p_div32;
    s_take(MDM_OP_DIV32) |-> ##17 done_r && !busy_r;
  endproperty
  a_div32: assert property (p_div32) else $error("long divide timing");

  property p_mac;
    s_take(MDM_OP_MAC) |=> (busy_r && !done_r)[*2] ##1 done_r;
  endproperty
  a_mac: assert property (p_mac) else $error("accumulate timing");

  property p_carry;
    s_take(MDM_OP_MAC) ##0 !sgn |-> ##3 carry_r == usum[32] && result_lo_r == usum[31:0];
  endproperty
  a_carry: assert property (p_carry) else $error("accumulate carry wrong");

  property p_excl;
    done_r |-> !busy_r;
  endproperty
  a_excl: assert property (p_excl) else $error("done while held");

  property p_release;
    $fell(busy_r) |-> done_r;
  endproperty
  a_release: assert property (p_release) else $error("hold dropped early");
endmodule // mdm_exec_unit_props

bind mdm_exec_unit mdm_exec_unit_props u_props (.clk(clk), .reset(reset), .start(start), .op(op),
  .sgn(sgn), .opa(opa), .opb(opb), .acc_in(acc_in), .busy_r(busy_r), .done_r(done_r),
  .result_lo_r(result_lo_r), .result_hi_r(result_hi_r), .carry_r(carry_r));

/* File: sim/mdm_decoder_model.sv */
`timescale 1ns/100ps

module mdm_decoder_model
(
  // Clock and hold
  input wire logic  clk,
  input wire logic  busy_r,
  // Issue
  output logic        start,
  output logic [2:0]  op,
  output logic        sgn,
  output logic [31:0] opa,
  output logic [31:0] opb,
  output logic [31:0] acc_in
);
  initial
    {start, op, sgn, opa, opb, acc_in} = '0;

  // Present an op and keep it up until an idle edge takes it
  task automatic issue(input logic [2:0] o, input logic s, input logic [31:0] a, b, c);
    logic idle;
    {start, op, sgn, opa, opb, acc_in} <= {1'b1, o, s, a, b, c};
    do
    begin
      @(negedge clk);
      idle = !busy_r;
      @(posedge clk);
    end
    while (!idle);
  endtask

  // Operands turn over once released, so stale values never pass
  task automatic quiet();
    {start, opa, opb, acc_in} <= {1'b0, ~opa, ~opb, ~acc_in};
  endtask
endmodule // mdm_decoder_model

/* File: sim/mdm_exec_unit_tb.sv */
`timescale 1ns/100ps

module mdm_exec_unit_tb;
  import mdm_pkg::*;

  typedef struct packed {logic [31:0] lo; logic [31:0] hi; logic c;} mdm_exp_t;

  logic        clk;
  logic        reset;
  logic        start;
  logic [2:0]  op;
  logic        sgn;
  logic [31:0] opa;
  logic [31:0] opb;
  logic [31:0] acc_in;
  logic        busy_r;
  logic        done_r;
  logic [31:0] result_lo_r;
  logic [31:0] result_hi_r;
  logic        carry_r;
  logic [31:0] lfsr_r;
  mdm_exp_t    last_e;
  mdm_exp_t    exp_q[$];
  mdm_exp_t    mon_e;
  int          errors;
  int          total_checks;
  int          cycles;

  mdm_exec_unit u_dut (.clk(clk), .reset(reset), .start(start), .op(op), .sgn(sgn), .opa(opa),
    .opb(opb), .acc_in(acc_in), .busy_r(busy_r), .done_r(done_r), .result_lo_r(result_lo_r),
    .result_hi_r(result_hi_r), .carry_r(carry_r));

  mdm_decoder_model u_dec (.clk(clk), .busy_r(busy_r), .start(start), .op(op), .sgn(sgn),
    .opa(opa), .opb(opb), .acc_in(acc_in));

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] rnd();
    lfsr_r = {lfsr_r[30:0], lfsr_r[31] ^ lfsr_r[21] ^ lfsr_r[1] ^ lfsr_r[0]};
    return lfsr_r;
  endfunction

  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      errors++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // Reference results; signed products kept apart from unsigned ones
  function automatic mdm_exp_t model_of(input logic [2:0] o, input logic s, input logic [31:0] a, b, c);
    logic signed [15:0] p8;
    logic signed [31:0] p16;
    logic [32:0] su;
    mdm_exp_t e;
    if (s)
    begin
      p8 = $signed(a[7:0]) * $signed(b[7:0]);
      p16 = $signed(a[15:0]) * $signed(b[15:0]);
    end
    else
    begin
      p8 = a[7:0] * b[7:0];
      p16 = a[15:0] * b[15:0];
    end
    su = {1'b0, c} + {1'b0, p16};
    e = '{lo: 32'h0, hi: 32'h0, c: last_e.c};
    case (o)
      MDM_OP_MUL8:  e.lo = {16'h0, p8};
      MDM_OP_MUL16: e.lo = p16;
      MDM_OP_DIV16:
      begin
        e.lo = (b[15:0] == 16'h0) ? 32'h0000ffff : a[15:0] / b[15:0];
        e.hi = (b[15:0] == 16'h0) ? a[15:0] : a[15:0] % b[15:0];
      end
      MDM_OP_DIV32:
      begin
        e.lo = (b == 32'h0) ? 32'hffffffff : a / b;
        e.hi = (b == 32'h0) ? a : a % b;
      end
      MDM_OP_MAC:
      begin
        e.lo = su[31:0];
        e.c = s ? (c[31] == p16[31] && su[31] != c[31]) : su[32];
      end
      default:
        e = last_e;
    endcase
    return e;
  endfunction

  // Note the expected result, then hand the op to the decoder model
  task automatic run(input logic [2:0] o, input logic s, input logic [31:0] a, b, c);
    mdm_exp_t e;
    e = model_of(o, s, a, b, c);
    last_e = e;
    exp_q.push_back(e);
    u_dec.issue(o, s, a, b, c);
  endtask

  task automatic test_done();
    if (errors == 0 && total_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Clock, watchdog and result monitor
  // ----------------------------------------------------------------
  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // Generous ceiling; the whole sequence needs a few hundred cycles
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      errors++;
      test_done();
    end
  end

  // Each write-back pulse retires the oldest note
  always @(negedge clk)
    if (done_r === 1'b1)
    begin
      if (exp_q.size() == 0)
        check("spare done", 32'h1, 32'h0);
      else
      begin
        mon_e = exp_q.pop_front();
        check("result lo", result_lo_r, mon_e.lo);
        check("result hi", result_hi_r, mon_e.hi);
        check("carry", {31'h0, carry_r}, {31'h0, mon_e.c});
      end
    end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial
  begin
    reset = 1'b1;
    lfsr_r = 32'h0000_0043;
    last_e = '0;
    repeat (12) @(posedge clk);
    reset <= 1'b0;
    // Every op back to back, both signs, random operands
    for (int i = 0; i < 30; i++)
      run(3'(i % 5), i[2], rnd(), rnd(), rnd());
    // Zero divisors, then carry set by wrap, overflow, underflow and cleared
    run(MDM_OP_DIV16, 1'b0, rnd(), 32'hffff0000, 32'h0);
    run(MDM_OP_DIV32, 1'b0, rnd(), 32'h0, 32'h0);
    run(MDM_OP_MAC, 1'b0, 32'h1, 32'h1, 32'hffffffff);
    run(MDM_OP_MAC, 1'b1, 32'h1, 32'h1, 32'h7fffffff);
    run(MDM_OP_MAC, 1'b1, 32'h0000ffff, 32'h1, 32'h80000000);
    run(MDM_OP_MUL8, 1'b1, 32'h80, 32'h7f, 32'h0);
    run(MDM_OP_MAC, 1'b0, 32'h2, 32'h3, 32'h5);
    // Unused code: done at once, results and carry left as they were
    run(3'h7, 1'b1, rnd(), rnd(), rnd());
    // Reset in the middle of a long divide
    u_dec.issue(MDM_OP_DIV32, 1'b0, rnd(), 32'h3, 32'h0);
    u_dec.quiet();
    repeat (5) @(posedge clk);
    reset <= 1'b1;
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    last_e = '0;
    @(negedge clk);
    check("lo after reset", result_lo_r, 32'h0);
    check("busy after reset", {31'h0, busy_r}, 32'h0);
    @(posedge clk);
    run(MDM_OP_MUL16, 1'b0, 32'hffff, 32'hffff, 32'h0);
    u_dec.quiet();
    repeat (30) @(posedge clk);
    check("notes left", exp_q.size(), 32'h0);
    test_done();
  end
endmodule // mdm_exec_unit_tb
